//--- rtl/ext_regs_pkg.sv
// Package with the offsets, field positions and reset values of the socket extension registers.
package ext_regs_pkg;
  localparam logic [7:0] IDX_EXT_INDEX = 8'h2e;
  localparam logic [7:0] IDX_EXT_DATA = 8'h2f;
  localparam logic [7:0] IDX_CHIP_INFO = 8'h1f;
  localparam logic [7:0] XIDX_SCRATCH = 8'h00;
  localparam logic [7:0] XIDX_EXT_CTRL = 8'h03;
  localparam logic [7:0] XIDX_WIN_FIRST = 8'h05;
  localparam logic [7:0] XIDX_WIN_LAST = 8'h09;
  localparam logic [7:0] XIDX_MM_CTRL = 8'h25;
  localparam logic [7:0] XIDX_SIL_REV = 8'h34;
  localparam logic [7:0] XIDX_ID_FIRST = 8'h35;
  localparam logic [7:0] XIDX_ID_LAST = 8'h37;
  localparam logic [7:0] XIDX_IMPL_FIRST = 8'h38;
  localparam logic [7:0] XIDX_IMPL_LAST = 8'h3b;
  localparam int EC_PWR_LOCK = 0;
  localparam int EC_AUTO_CLR = 1;
  localparam int EC_LAMP_EN = 2;
  localparam int EC_CIRQ_INV = 3;
  localparam int EC_MIRQ_INV = 4;
  localparam int EC_PULLUP_OFF = 5;
  localparam logic [7:0] EC_MASK = 8'h3f;
  localparam int MM_EXPAND = 6;
  localparam int MM_ARM = 7;
  localparam logic [7:0] MM_MASK = 8'hc0;
  localparam int PWR_VCC_BIT = 4;
  localparam int NUM_WIN = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_IMPL_A = 8'h09;
endpackage : ext_regs_pkg

//--- rtl/byte_store.sv
// Small register array with registered read data, used for window bytes and implementation bytes.
module byte_store #(
  parameter int DEPTH = 5,
  parameter int AW = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata,
  output logic [DEPTH*8-1:0] all_bytes
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rd;
  } store_t;
  store_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (we && (int'(waddr) < DEPTH)) begin
      s_d.mem[waddr] = wdata;
    end
    s_d.rd = (int'(raddr) < DEPTH) ? s_q.mem[raddr] : 8'h00;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rdata = s_q.rd;
  assign all_bytes = s_q.mem;
endmodule : byte_store

//--- rtl/socket_extension_registers.sv
// Extended per-socket register bank behind the index/data pair, with its socket side effects.
module socket_extension_registers #(
  parameter logic [7:0] SILICON_REV = 8'h01,
  parameter logic [7:0] ID_BYTE_0 = 8'h5a,
  parameter logic [7:0] ID_BYTE_1 = 8'h00,
  parameter logic [7:0] ID_BYTE_2 = 8'h00,
  parameter logic [7:0] CHIP_INFO_EXT = 8'h3c
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] chip_info,
  input wire logic pwr_wr,
  input wire logic [7:0] pwr_wdata,
  output logic vcc_enable,
  input wire logic card_present_raw,
  output logic detect_pullup_en,
  output logic card_inserted,
  output logic card_removed,
  output logic card_detect_irq,
  input wire logic card_cycle_active,
  output logic activity_lamp_n,
  input wire logic card_irq_req,
  output logic card_irq_o,
  output logic card_irq_oe,
  input wire logic mgmt_irq_req,
  output logic mgmt_irq_o,
  output logic mgmt_irq_oe,
  input wire logic [31:0] host_addr,
  input wire logic [ext_regs_pkg::NUM_WIN-1:0] win_base_hit,
  output logic [ext_regs_pkg::NUM_WIN-1:0] win_hit,
  input wire logic mm_enable,
  output logic mm_active,
  output logic mm_bus_float
);
  typedef struct packed {
    logic [7:0] xindex;
    logic [7:0] scratch;
    logic [7:0] ext_ctrl;
    logic [7:0] mm_ctrl;
    logic [7:0] rdata;
    logic rvalid;
    logic vcc;
    logic present;
    logic ins;
    logic rem;
    logic cd_irq;
    logic lamp_n;
    logic cirq_o;
    logic cirq_oe;
    logic mirq_o;
    logic mirq_oe;
    logic pull_en;
    logic [ext_regs_pkg::NUM_WIN-1:0] hit;
    logic mm_act;
    logic mm_float;
  } state_t;
  state_t q, d;

  logic data_wr, data_rd, ext_ok, win_sel, impl_sel, rd_pend_q;
  logic [7:0] win_rd, impl_rd, data_val;
  logic [ext_regs_pkg::NUM_WIN*8-1:0] win_bytes;
  logic [2:0] win_addr, impl_addr;
  logic sense, mm_on;

  assign data_wr = reg_wr && (reg_index == ext_regs_pkg::IDX_EXT_DATA);
  assign data_rd = reg_rd && (reg_index == ext_regs_pkg::IDX_EXT_DATA);
  assign ext_ok = (chip_info == CHIP_INFO_EXT);
  assign win_sel = (q.xindex >= ext_regs_pkg::XIDX_WIN_FIRST) &&
                   (q.xindex <= ext_regs_pkg::XIDX_WIN_LAST);
  assign impl_sel = ext_ok && (q.xindex >= ext_regs_pkg::XIDX_IMPL_FIRST) &&
                    (q.xindex <= ext_regs_pkg::XIDX_IMPL_LAST);
  assign win_addr = 3'(q.xindex - ext_regs_pkg::XIDX_WIN_FIRST);
  assign impl_addr = 3'(q.xindex - ext_regs_pkg::XIDX_IMPL_FIRST);

  // Window bytes are held in the store; read data arrive one cycle later.
  byte_store #(.DEPTH(ext_regs_pkg::NUM_WIN), .AW(3)) u_win (
    .clock(clock),
    .rst_n(rst_n),
    .we(data_wr && win_sel),
    .waddr(win_addr),
    .wdata(reg_wdata),
    .raddr(win_addr),
    .rdata(win_rd),
    .all_bytes(win_bytes)
  );

  // The store resets to zero, so the implementation defaults are xored in on both paths.
  logic [31:0] impl_bytes;
  byte_store #(.DEPTH(4), .AW(3)) u_impl (
    .clock(clock),
    .rst_n(rst_n),
    .we(data_wr && impl_sel),
    .waddr(impl_addr),
    .wdata(reg_wdata ^ ((impl_addr == 3'h0) ? ext_regs_pkg::RST_IMPL_A : 8'h00)),
    .raddr(impl_addr),
    .rdata(impl_rd),
    .all_bytes(impl_bytes)
  );

  logic [7:0] xindex_rd_q;

  always_comb begin
    data_val = 8'h00;
    case (xindex_rd_q)
      ext_regs_pkg::XIDX_SCRATCH: data_val = q.scratch;
      ext_regs_pkg::XIDX_EXT_CTRL: data_val = q.ext_ctrl & ext_regs_pkg::EC_MASK;
      ext_regs_pkg::XIDX_MM_CTRL: data_val = q.mm_ctrl & ext_regs_pkg::MM_MASK;
      ext_regs_pkg::XIDX_SIL_REV: data_val = ext_ok ? SILICON_REV : 8'h00;
      8'h35: data_val = ext_ok ? ID_BYTE_0 : 8'h00;
      8'h36: data_val = ext_ok ? ID_BYTE_1 : 8'h00;
      ext_regs_pkg::XIDX_ID_LAST: data_val = ext_ok ? ID_BYTE_2 : 8'h00;
      default: begin
        if (xindex_rd_q >= ext_regs_pkg::XIDX_WIN_FIRST &&
            xindex_rd_q <= ext_regs_pkg::XIDX_WIN_LAST) begin
          data_val = win_rd;
        end else if (ext_ok && xindex_rd_q >= ext_regs_pkg::XIDX_IMPL_FIRST &&
                     xindex_rd_q <= ext_regs_pkg::XIDX_IMPL_LAST) begin
          data_val = impl_rd ^ ((xindex_rd_q == ext_regs_pkg::XIDX_IMPL_FIRST) ?
                                ext_regs_pkg::RST_IMPL_A : 8'h00);
        end else begin
          data_val = 8'h00;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q <= 1'b0;
      xindex_rd_q <= 8'h00;
    end else begin
      rd_pend_q <= reg_rd;
      xindex_rd_q <= (reg_index == ext_regs_pkg::IDX_EXT_DATA) ? q.xindex : 8'hff;
    end
  end

  // Detect sensing is gated off with the pull-ups, since the inputs float then.
  assign sense = !q.ext_ctrl[ext_regs_pkg::EC_PULLUP_OFF] && card_present_raw;
  assign mm_on = q.mm_ctrl[ext_regs_pkg::MM_ARM] && mm_enable;

  always_comb begin
    d = q;
    d.ins = 1'b0;
    d.rem = 1'b0;
    d.cd_irq = 1'b0;
    d.rvalid = rd_pend_q;
    d.rdata = rd_pend_q ? ((xindex_rd_q == 8'hff) ? q.xindex : data_val) : 8'h00;
    if (reg_wr && reg_index == ext_regs_pkg::IDX_EXT_INDEX) begin
      d.xindex = reg_wdata;
    end
    if (data_wr) begin
      case (q.xindex)
        ext_regs_pkg::XIDX_SCRATCH: d.scratch = reg_wdata;
        ext_regs_pkg::XIDX_EXT_CTRL: d.ext_ctrl = reg_wdata & ext_regs_pkg::EC_MASK;
        ext_regs_pkg::XIDX_MM_CTRL: d.mm_ctrl = reg_wdata & ext_regs_pkg::MM_MASK;
        default: d.scratch = q.scratch;
      endcase
      if (q.xindex == ext_regs_pkg::XIDX_EXT_CTRL &&
          reg_wdata[ext_regs_pkg::EC_PULLUP_OFF] &&
          !q.ext_ctrl[ext_regs_pkg::EC_PULLUP_OFF] && q.present) begin
        d.cd_irq = 1'b1;
      end
    end
    if (pwr_wr && !q.ext_ctrl[ext_regs_pkg::EC_PWR_LOCK]) begin
      d.vcc = pwr_wdata[ext_regs_pkg::PWR_VCC_BIT];
    end
    if (!q.ext_ctrl[ext_regs_pkg::EC_PULLUP_OFF]) begin
      d.present = sense;
      d.ins = sense && !q.present;
      d.rem = !sense && q.present;
      if (d.rem) begin
        d.cd_irq = 1'b1;
      end
      if (d.ins) begin
        d.cd_irq = 1'b1;
      end
      if (d.rem && !q.ext_ctrl[ext_regs_pkg::EC_AUTO_CLR]) begin
        d.vcc = 1'b0;
      end
    end
    d.lamp_n = !(q.ext_ctrl[ext_regs_pkg::EC_LAMP_EN] && card_cycle_active);
    if (q.ext_ctrl[ext_regs_pkg::EC_CIRQ_INV]) begin
      d.cirq_o = 1'b0;
      d.cirq_oe = card_irq_req;
    end else begin
      d.cirq_o = card_irq_req;
      d.cirq_oe = 1'b1;
    end
    if (q.ext_ctrl[ext_regs_pkg::EC_MIRQ_INV]) begin
      d.mirq_o = 1'b0;
      d.mirq_oe = mgmt_irq_req;
    end else begin
      d.mirq_o = mgmt_irq_req;
      d.mirq_oe = 1'b1;
    end
    d.pull_en = !q.ext_ctrl[ext_regs_pkg::EC_PULLUP_OFF];
    for (int i = 0; i < ext_regs_pkg::NUM_WIN; i++) begin
      d.hit[i] = win_base_hit[i] && (host_addr[31:24] == win_bytes[i*8 +: 8]);
    end
    d.mm_act = mm_on;
    d.mm_float = mm_on && q.mm_ctrl[ext_regs_pkg::MM_EXPAND];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.lamp_n <= 1'b1;
      q.cirq_oe <= 1'b1;
      q.mirq_oe <= 1'b1;
      q.pull_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign vcc_enable = q.vcc;
  assign detect_pullup_en = q.pull_en;
  assign card_inserted = q.ins;
  assign card_removed = q.rem;
  assign card_detect_irq = q.cd_irq;
  assign activity_lamp_n = q.lamp_n;
  assign card_irq_o = q.cirq_o;
  assign card_irq_oe = q.cirq_oe;
  assign mgmt_irq_o = q.mirq_o;
  assign mgmt_irq_oe = q.mirq_oe;
  assign win_hit = q.hit;
  assign mm_active = q.mm_act;
  assign mm_bus_float = q.mm_float;
endmodule : socket_extension_registers

//--- testbench/card_model.sv
// Behavioural card in the socket: detect level, bus activity and interrupt request.
module card_model (
  input wire logic inserted,
  input wire logic busy,
  input wire logic irq,
  output logic card_present_raw,
  output logic card_cycle_active,
  output logic card_irq_req
);
  // A card that is pulled out can neither run cycles nor ask for service.
  assign card_present_raw = inserted;
  assign card_cycle_active = inserted & busy;
  assign card_irq_req = inserted & irq;
endmodule : card_model

//--- testbench/ext_checker_properties.sv
// Port-level checker for the socket extension register bank.
module ext_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic card_cycle_active,
  input wire logic activity_lamp_n,
  input wire logic card_irq_req,
  input wire logic card_irq_o,
  input wire logic card_irq_oe,
  input wire logic mgmt_irq_req,
  input wire logic mgmt_irq_o,
  input wire logic mgmt_irq_oe,
  input wire logic [ext_regs_pkg::NUM_WIN-1:0] win_base_hit,
  input wire logic [ext_regs_pkg::NUM_WIN-1:0] win_hit,
  input wire logic mm_enable,
  input wire logic mm_active,
  input wire logic mm_bus_float,
  input wire logic detect_pullup_en,
  input wire logic card_removed,
  input wire logic card_detect_irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_READ: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read answer late");
  AST_LAMP: assert property (!$past(card_cycle_active) |-> activity_lamp_n)
    else $error("lamp lit while idle");
  AST_CIRQ_HI: assert property (card_irq_o |-> card_irq_oe && $past(card_irq_req))
    else $error("card irq high wrongly");
  AST_CIRQ_OFF: assert property (!card_irq_oe |-> !card_irq_o && !$past(card_irq_req))
    else $error("card irq released wrongly");
  AST_MIRQ_HI: assert property (mgmt_irq_o |-> mgmt_irq_oe && $past(mgmt_irq_req))
    else $error("mgmt irq high wrongly");
  AST_WIN: assert property ((win_hit & ~$past(win_base_hit)) == 5'h00)
    else $error("window hit without base hit");
  AST_FLOAT: assert property (mm_bus_float |-> mm_active && $past(mm_enable))
    else $error("bus floated wrongly");
  AST_ARM: assert property ($rose(mm_active) |-> $past(mm_enable))
    else $error("multimedia without enable");
  AST_REMOVE: assert property (card_removed |-> card_detect_irq && $past(detect_pullup_en))
    else $error("removal while sensing off");
  COV_READ: cover property (reg_rvalid);
  COV_REMOVE: cover property (card_removed);
  COV_FLOAT: cover property (mm_bus_float);
  COV_OPEN_DRAIN: cover property (!card_irq_oe);
endmodule : ext_checker

bind socket_extension_registers ext_checker i_ext_checker (.clock, .rst_n, .reg_rd, .reg_rvalid,
  .card_cycle_active, .activity_lamp_n, .card_irq_req, .card_irq_o, .card_irq_oe, .mgmt_irq_req,
  .mgmt_irq_o, .mgmt_irq_oe, .win_base_hit, .win_hit, .mm_enable, .mm_active, .mm_bus_float,
  .detect_pullup_en, .card_removed, .card_detect_irq);

//--- testbench/test_socket_extension_registers.sv
// Self-checking bench for the socket extension register bank.
module test_socket_extension_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pwr_wr = 1'b0;
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, pwr_wdata = 8'h00, chip_info = 8'h3c;
  logic mgmt_irq_req = 1'b0, mm_enable = 1'b0, inserted = 1'b0, busy = 1'b0, irq = 1'b0;
  logic [31:0] host_addr = 32'h0000_0000;
  logic [4:0] win_base_hit = 5'h00, win_hit;
  logic [7:0] reg_rdata;
  logic reg_rvalid, vcc_enable, detect_pullup_en, card_inserted, card_removed, card_detect_irq;
  logic card_present_raw, card_cycle_active, card_irq_req, activity_lamp_n;
  logic card_irq_o, card_irq_oe, mgmt_irq_o, mgmt_irq_oe, mm_active, mm_bus_float;
  int miscompares = 0, tests_run = 0, rm_cnt = 0, det_cnt = 0, ins_cnt = 0;
  // Both values are arbitrary.
  socket_extension_registers #(.SILICON_REV(8'h6e), .ID_BYTE_0(8'ha5))
    i_socket_extension_registers (.clock, .rst_n, .reg_wr, .reg_rd, .reg_index, .reg_wdata,
    .reg_rdata, .reg_rvalid, .chip_info, .pwr_wr, .pwr_wdata, .vcc_enable, .card_present_raw,
    .detect_pullup_en, .card_inserted, .card_removed, .card_detect_irq, .card_cycle_active,
    .activity_lamp_n, .card_irq_req, .card_irq_o, .card_irq_oe, .mgmt_irq_req, .mgmt_irq_o,
    .mgmt_irq_oe, .host_addr, .win_base_hit, .win_hit, .mm_enable, .mm_active, .mm_bus_float);
  card_model i_card_model (.inserted, .busy, .irq, .card_present_raw, .card_cycle_active,
    .card_irq_req);
  initial begin
    forever #5 clock = ~clock;
  end
  // Status pulses last one cycle, so they are counted rather than sampled late.
  always @(posedge clock) begin
    if (card_removed === 1'b1) rm_cnt <= rm_cnt + 1;
    if (card_inserted === 1'b1) ins_cnt <= ins_cnt + 1;
    if (card_detect_irq === 1'b1) det_cnt <= det_cnt + 1;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clock);
    {reg_wr, reg_index, reg_wdata} = {1'b1, idx, d};
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic xw(input logic [7:0] xi, input logic [7:0] d);
    wr(8'h2e, xi);
    wr(8'h2f, d);
    repeat (2) @(negedge clock);
  endtask : xw
  task automatic xchk(input logic [7:0] xi, input logic [7:0] exp);
    int n;
    wr(8'h2e, xi);
    @(negedge clock);
    {reg_rd, reg_index} = {1'b1, 8'h2f};
    @(negedge clock);
    reg_rd = 1'b0;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (reg_rvalid !== 1'b1) begin
      miscompares++;
      complete_run();
    end
    check(reg_rdata, exp);
    // Return on a falling edge so that the next stimulus stays off the sampling edge.
    @(negedge clock);
  endtask : xchk
  task automatic pwr(input logic [7:0] d, input logic exp);
    @(negedge clock);
    {pwr_wr, pwr_wdata} = {1'b1, d};
    @(negedge clock);
    pwr_wr = 1'b0;
    @(negedge clock);
    check(vcc_enable, exp);
  endtask : pwr
  task automatic t_regs;
    int i;
    for (i = 0; i < 5; i++) xw(8'h05 + 8'(i), 8'h80 + 8'(i));
    for (i = 0; i < 5; i++) xchk(8'h05 + 8'(i), 8'h80 + 8'(i));
    {host_addr, win_base_hit} = {32'h8212_3456, 5'h1f};
    repeat (2) @(negedge clock);
    check(win_hit, 8'h04);
    xw(8'h34, 8'hff);
    xchk(8'h34, 8'h6e);
    xchk(8'h35, 8'ha5);
    xchk(8'h38, 8'h09);
    xw(8'h38, 8'h77);
    xchk(8'h38, 8'h77);
    chip_info = 8'h00;
    xchk(8'h38, 8'h00);
    xw(8'h03, 8'hff);
    xchk(8'h03, 8'h3f);
    xw(8'h25, 8'hff);
    xchk(8'h25, 8'hc0);
    xw(8'h03, 8'h00);
  endtask : t_regs
  task automatic t_power;
    int r0, i0;
    i0 = ins_cnt;
    inserted = 1'b1;
    pwr(8'h10, 1'b1);
    check(8'(ins_cnt - i0), 8'h01);
    xw(8'h03, 8'h01);
    pwr(8'h00, 1'b1);
    xw(8'h03, 8'h00);
    pwr(8'h00, 1'b0);
    pwr(8'h10, 1'b1);
    r0 = rm_cnt;
    inserted = 1'b0;
    repeat (2) @(negedge clock);
    check(8'(rm_cnt - r0), 8'h01);
    check(vcc_enable, 1'b0);
    inserted = 1'b1;
    xw(8'h03, 8'h02);
    pwr(8'h10, 1'b1);
    inserted = 1'b0;
    repeat (2) @(negedge clock);
    check(vcc_enable, 1'b1);
  endtask : t_power
  task automatic t_pullup;
    int d0, r0;
    inserted = 1'b1;
    xw(8'h03, 8'h00);
    d0 = det_cnt;
    xw(8'h03, 8'h20);
    check(detect_pullup_en, 1'b0);
    check(8'(det_cnt - d0), 8'h01);
    r0 = rm_cnt;
    inserted = 1'b0;
    repeat (2) @(negedge clock);
    check(8'(rm_cnt - r0), 8'h00);
  endtask : t_pullup
  task automatic t_pins;
    {inserted, busy, irq, mgmt_irq_req, mm_enable} = 5'h1f;
    xw(8'h03, 8'h04);
    check(activity_lamp_n, 1'b0);
    xw(8'h03, 8'h00);
    check({activity_lamp_n, card_irq_o, card_irq_oe, mgmt_irq_o, mgmt_irq_oe}, 8'h1f);
    xw(8'h03, 8'h18);
    check({card_irq_o, card_irq_oe, mgmt_irq_o, mgmt_irq_oe}, 8'h05);
    {irq, mgmt_irq_req} = 2'b00;
    repeat (2) @(negedge clock);
    check({card_irq_o, card_irq_oe, mgmt_irq_o, mgmt_irq_oe}, 8'h00);
    xw(8'h25, 8'h40);
    check({mm_active, mm_bus_float}, 8'h00);
    xw(8'h25, 8'hc0);
    check({mm_active, mm_bus_float}, 8'h03);
    xw(8'h25, 8'h80);
    check({mm_active, mm_bus_float}, 8'h02);
  endtask : t_pins
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    t_regs();
    t_power();
    t_pullup();
    t_pins();
    complete_run();
  end
endmodule : test_socket_extension_registers
